// >>> logic/vts_pkg.sv
// Shared constants, codes and carriers of the voltage transformer supervision block.
// Assumes magnitudes in 0.01 x Un steps and angles in 0.1 degree steps.
package vts_pkg;
    localparam int MAG_W = 12;
    localparam int ANG_W = 12;
    localparam int NCH = 3;
    localparam int UPDATE_MS = 5;
    localparam int ANGLE_LAG_MS = 40;
    localparam int PREFAULT_MS = 20;
    localparam int HIST_N = ANGLE_LAG_MS / UPDATE_MS;
    localparam int PF_N = PREFAULT_MS / UPDATE_MS;
    localparam int CLK_HZ = 100_000_000;
    localparam int STAMP_MS = 1;
    localparam int STAMP_CYC = CLK_HZ / 1000 * STAMP_MS;
    localparam int DLY_W = 19;
    localparam logic [DLY_W-1:0] DLY_MAX = 19'h57E40;
    localparam logic [DLY_W-1:0] DLY_RST = 19'h000C8;
    localparam logic [ANG_W-1:0] ANG_FULL = 12'hE10;
    localparam logic [ANG_W-1:0] ANG_HALF = 12'h708;
    localparam logic [MAG_W-1:0] DEAD_LIM = 12'h005;

    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h04;
    localparam logic [7:0] OFS_LOW = 8'h08;
    localparam logic [7:0] OFS_HIGH = 8'h0C;
    localparam logic [7:0] OFS_ANG = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_DLY = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_REMAIN = 8'h20;
    localparam logic [7:0] OFS_PF0 = 8'h24;

    localparam logic [2:0] FORCE_RST = 3'h0;
    localparam logic [6:0] LOW_RST = 7'h05;
    localparam logic [6:0] LOW_MIN = 7'h05;
    localparam logic [6:0] LOW_MAX = 7'h32;
    localparam logic [6:0] HIGH_RST = 7'h50;
    localparam logic [6:0] HIGH_MIN = 7'h01;
    localparam logic [6:0] HIGH_MAX = 7'h6E;
    localparam logic [9:0] ANG_RST = 10'h032;
    localparam logic [9:0] ANG_MIN = 10'h014;
    localparam logic [9:0] ANG_MAX = 10'h384;
    localparam logic [2:0] CTRL_RST = 3'h3;
    localparam int CTRL_BUS_CHK = 0;
    localparam int CTRL_LINE_CHK = 1;
    localparam int CTRL_PHASE_SEL = 2;
    localparam int ST_OUT_LSB = 0;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_COND_LSB = 8;
    localparam int ST_BUS_LSB = 12;
    localparam int ST_PU_BIT = 16;

    typedef enum logic [2:0] {
        MODE_ON = 3'h1, MODE_BLOCKED = 3'h2, MODE_TEST = 3'h3,
        MODE_TEST_BLK = 3'h4, MODE_OFF = 3'h5
    } vts_mode_e;
    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0, COND_START = 3'h1, COND_LINE_FAIL = 3'h2,
        COND_BUS_FAIL = 3'h3, COND_BLOCKED = 3'h4
    } vts_cond_e;
    typedef enum logic [2:0] {
        BUS_DEAD = 3'h0, BUS_OK = 3'h1, BUS_REV = 3'h2,
        BUS_UNDEF = 3'h3, BUS_PROBLEM = 3'h4
    } vts_bus_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_TIME = 2'b01, ST_ALARM = 2'b10
    } vts_st_e;

    typedef struct packed {
        logic [NCH-1:0][MAG_W-1:0] line_mag;
        logic [NCH-1:0][MAG_W-1:0] phase_mag;
        logic [NCH-1:0][ANG_W-1:0] line_ang;
        logic [NCH-1:0][ANG_W-1:0] phase_ang;
        logic [MAG_W-1:0] positive_seq_voltage;
        logic [MAG_W-1:0] negative_seq_voltage;
        logic [MAG_W-1:0] zero_seq_voltage;
    } vts_meas_s;
    typedef struct packed {
        logic blocked;
        logic alarm_line;
        logic alarm_bus;
        logic start;
    } vts_out_s;
    typedef struct packed {
        logic [3:0] rise;
        logic [3:0] fall;
        logic [31:0] stamp_ms;
    } vts_evt_s;
endpackage

// >>> logic/vts_supervision.sv
// Voltage transformer supervision core with its APB register file and event stamping.
// Assumes meas_valid strobes once per 5 ms update and an APB master on clk_sys.
module vts_supervision
    import vts_pkg::*;
#(
    parameter int STAMP_CYCLES = STAMP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire vts_meas_s meas,
    input wire logic block_in,
    input wire logic bus_breaker_trip_input,
    input wire logic line_breaker_trip_input,
    input wire logic stage_forcing_en,
    output vts_out_s outs,
    output logic evt_valid,
    output vts_evt_s evt
);
    localparam int MSC_W = $clog2(STAMP_CYCLES);
    localparam int CNT_W = DLY_W + 1;

    logic [2:0] mode_r;
    logic [2:0] force_r;
    logic [6:0] low_r;
    logic [6:0] high_r;
    logic [9:0] ang_lim_r;
    logic [2:0] ctrl_r;
    logic [DLY_W-1:0] dly_r;
    vts_st_e st_r;
    vts_st_e st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    vts_out_s outs_r;
    vts_out_s outs_nxt;
    logic [2:0] cond_r;
    logic [2:0] cond_nxt;
    logic [2:0] bus_r;
    logic pickup_r;
    logic [MAG_W-1:0] pf_r [NCH];
    logic [NCH-1:0] lo_v;
    logic [NCH-1:0] hi_v;
    logic [NCH-1:0] small_v;
    logic [NCH-1:0] dead_v;
    logic [NCH-1:0] pf_hit;
    logic [31:0] pf_or;
    logic [31:0] stat_w;
    logic [MSC_W-1:0] msc_r;
    logic [31:0] stamp_r;
    logic evt_valid_r;
    vts_evt_s evt_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic vld_r;
    logic cap;

    // Bus slave: read data is caught in the setup cycle, so access has no wait state.
    wire upd = clk_en & meas_valid;
    wire apb_done = psel & penable & pready;
    wire wr = apb_done & pwrite;
    assign pready = psel & penable & clk_en & vld_r;

    wire hit_mode = paddr == OFS_MODE;
    wire hit_force = paddr == OFS_FORCE;
    wire hit_low = paddr == OFS_LOW;
    wire hit_high = paddr == OFS_HIGH;
    wire hit_ang = paddr == OFS_ANG;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_dly = paddr == OFS_DLY;
    wire hit_stat = paddr == OFS_STAT;
    wire hit_rem = paddr == OFS_REMAIN;
    wire known = hit_mode | hit_force | hit_low | hit_high | hit_ang | hit_ctrl
        | hit_dly | hit_stat | hit_rem | (|pf_hit);

    // Out-of-range setting writes are dropped so the block never runs on an illegal code.
    wire ok_mode = pwdata >= 32'(MODE_ON) && pwdata <= 32'(MODE_OFF);
    wire ok_force = pwdata <= 32'(COND_BLOCKED);
    wire ok_low = pwdata >= 32'(LOW_MIN) && pwdata <= 32'(LOW_MAX);
    wire ok_high = pwdata >= 32'(HIGH_MIN) && pwdata <= 32'(HIGH_MAX);
    wire ok_ang = pwdata >= 32'(ANG_MIN) && pwdata <= 32'(ANG_MAX);
    wire ok_dly = pwdata <= 32'(DLY_MAX);
    wire we_mode = wr & hit_mode & ok_mode;
    wire we_force = wr & hit_force & ok_force;
    wire we_low = wr & hit_low & ok_low;
    wire we_high = wr & hit_high & ok_high;
    wire we_ang = wr & hit_ang & ok_ang;
    wire we_ctrl = wr & hit_ctrl;
    wire we_dly = wr & hit_dly & ok_dly;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_ON;
            force_r <= FORCE_RST;
            low_r <= LOW_RST;
            high_r <= HIGH_RST;
            ang_lim_r <= ANG_RST;
            ctrl_r <= CTRL_RST;
            dly_r <= DLY_RST;
        end else if (clk_en) begin
            if (we_mode) mode_r <= pwdata[2:0];
            if (we_force) force_r <= pwdata[2:0];
            if (we_low) low_r <= pwdata[6:0];
            if (we_high) high_r <= pwdata[6:0];
            if (we_ang) ang_lim_r <= pwdata[9:0];
            if (we_ctrl) ctrl_r <= pwdata[2:0];
            if (we_dly) dly_r <= pwdata[DLY_W-1:0];
        end
    end

    // Supervised channel set, history, angle shift and pre-fault average per channel.
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire [MAG_W-1:0] mag = ctrl_r[CTRL_PHASE_SEL] ? meas.phase_mag[c]
            : meas.line_mag[c];
        wire [ANG_W-1:0] ang = ctrl_r[CTRL_PHASE_SEL] ? meas.phase_ang[c]
            : meas.line_ang[c];
        logic [MAG_W-1:0] mh_r [HIST_N];
        logic [ANG_W-1:0] ah_r [HIST_N];
        logic [MAG_W+1:0] sum;
        wire [ANG_W-1:0] old = ah_r[HIST_N-1];
        wire [ANG_W-1:0] d0 = (ang >= old) ? ang - old : old - ang;
        wire [ANG_W-1:0] adiff = (d0 > ANG_HALF) ? ANG_FULL - d0 : d0;
        assign lo_v[c] = mag < {5'h00, low_r};
        assign hi_v[c] = mag > {5'h00, high_r};
        assign small_v[c] = adiff < {2'h0, ang_lim_r};
        assign dead_v[c] = mag < DEAD_LIM;
        assign pf_hit[c] = paddr == OFS_PF0 + 8'(4 * c);

        always_comb begin
            sum = '0;
            for (int i = HIST_N - PF_N; i < HIST_N; i++) begin
                sum = sum + {2'b00, mh_r[i]};
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                for (int i = 0; i < HIST_N; i++) begin
                    mh_r[i] <= '0;
                    ah_r[i] <= '0;
                end
                pf_r[c] <= '0;
            end else if (upd) begin
                mh_r[0] <= mag;
                ah_r[0] <= ang;
                for (int i = 1; i < HIST_N; i++) begin
                    mh_r[i] <= mh_r[i-1];
                    ah_r[i] <= ah_r[i-1];
                end
                if (cap) pf_r[c] <= MAG_W'(sum / (MAG_W + 2)'(PF_N));
            end
        end
    end

    always_comb begin
        pf_or = '0;
        for (int c = 0; c < NCH; c++) begin
            if (pf_hit[c]) pf_or = pf_or | {20'h00000, pf_r[c]};
        end
    end

    // Pick-up sources and blocking, all sampled at the update strobe.
    wire hi2 = (hi_v[0] & hi_v[1]) | (hi_v[0] & hi_v[2]) | (hi_v[1] & hi_v[2]);
    wire volt_pu = ((|lo_v) | hi2) & ~(&small_v);
    wire fuse_bus = ctrl_r[CTRL_BUS_CHK] & bus_breaker_trip_input;
    wire fuse_line = ctrl_r[CTRL_LINE_CHK] & line_breaker_trip_input;
    wire pickup = volt_pu | fuse_bus | fuse_line;
    wire is_off = mode_r == MODE_OFF;
    wire blk = block_in | (mode_r == MODE_BLOCKED) | (mode_r == MODE_TEST_BLK);
    wire run = pickup & ~blk;
    wire [CNT_W-1:0] cnt_cap = {1'b0, dly_r} + {1'b0, DLY_MAX};
    wire [CNT_W-1:0] cnt_inc = (cnt_r >= cnt_cap) ? cnt_r : cnt_r + 1'b1;

    always_comb begin
        st_nxt = ST_IDLE;
        outs_nxt = '0;
        cond_nxt = COND_NORMAL;
        unique case (st_r)
            ST_IDLE: cnt_nxt = '0;
            ST_TIME, ST_ALARM: cnt_nxt = cnt_inc;
            default: cnt_nxt = '0;
        endcase
        if (run) begin
            st_nxt = (cnt_nxt >= {1'b0, dly_r}) ? ST_ALARM : ST_TIME;
        end else begin
            cnt_nxt = '0;
        end
        outs_nxt.start = run;
        outs_nxt.blocked = pickup & blk;
        if (st_nxt == ST_ALARM) begin
            outs_nxt.alarm_line = fuse_line;
            outs_nxt.alarm_bus = fuse_bus | volt_pu;
        end
        if (outs_nxt.blocked) cond_nxt = COND_BLOCKED;
        else if (outs_nxt.alarm_line) cond_nxt = COND_LINE_FAIL;
        else if (outs_nxt.alarm_bus) cond_nxt = COND_BUS_FAIL;
        else if (outs_nxt.start) cond_nxt = COND_START;
        if (stage_forcing_en) begin
            st_nxt = ST_IDLE;
            cnt_nxt = '0;
            cond_nxt = force_r;
            outs_nxt.start = force_r == COND_START;
            outs_nxt.alarm_line = force_r == COND_LINE_FAIL;
            outs_nxt.alarm_bus = force_r == COND_BUS_FAIL;
            outs_nxt.blocked = force_r == COND_BLOCKED;
        end
        if (is_off) begin
            st_nxt = ST_IDLE;
            cnt_nxt = '0;
            outs_nxt = '0;
            cond_nxt = COND_NORMAL;
        end
    end

    // Sequence check: a large zero sequence leaves the rotation undefined.
    wire [MAG_W-1:0] ps = meas.positive_seq_voltage;
    wire [MAG_W-1:0] ns = meas.negative_seq_voltage;
    wire [MAG_W-1:0] zs = meas.zero_seq_voltage;
    wire [2:0] seq_code = (ps > ns && zs <= ps) ? BUS_OK
        : (ns > ps && zs <= ns) ? BUS_REV : BUS_UNDEF;
    wire [2:0] bus_nxt = (is_off | (&dead_v)) ? BUS_DEAD
        : pickup ? BUS_PROBLEM : seq_code;

    assign cap = (outs_nxt.start & ~outs_r.start)
        | ((outs_nxt.alarm_bus | outs_nxt.alarm_line) & ~(outs_r.alarm_bus | outs_r.alarm_line));
    wire chg = outs_nxt != outs_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            outs_r <= '0;
            cond_r <= COND_NORMAL;
            bus_r <= BUS_DEAD;
            pickup_r <= 1'b0;
        end else if (upd) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            outs_r <= outs_nxt;
            cond_r <= cond_nxt;
            bus_r <= bus_nxt;
            pickup_r <= pickup & ~is_off;
        end
    end

    // Millisecond stamp; the event carries all edges of one update in one word.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msc_r <= '0;
            stamp_r <= '0;
            evt_valid_r <= 1'b0;
            evt_r <= '0;
        end else if (clk_en) begin
            msc_r <= (msc_r == MSC_W'(STAMP_CYCLES - 1)) ? '0 : msc_r + 1'b1;
            if (msc_r == MSC_W'(STAMP_CYCLES - 1)) stamp_r <= stamp_r + 1'b1;
            evt_valid_r <= upd & chg;
            if (upd & chg) begin
                evt_r.rise <= outs_nxt & ~outs_r;
                evt_r.fall <= ~outs_nxt & outs_r;
                evt_r.stamp_ms <= stamp_r;
            end
        end
    end

    wire signed [CNT_W:0] remain = (st_r == ST_IDLE) ? '0
        : $signed({2'b00, dly_r}) - $signed({1'b0, cnt_r});

    always_comb begin
        stat_w = '0;
        stat_w[ST_OUT_LSB +: 4] = outs_r;
        stat_w[ST_MODE_LSB +: 3] = mode_r;
        stat_w[ST_COND_LSB +: 3] = cond_r;
        stat_w[ST_BUS_LSB +: 3] = bus_r;
        stat_w[ST_PU_BIT] = pickup_r;
    end

    wire [31:0] rd_val = hit_mode ? {29'h0, mode_r}
        : hit_force ? {29'h0, force_r}
        : hit_low ? {25'h0, low_r}
        : hit_high ? {25'h0, high_r}
        : hit_ang ? {22'h0, ang_lim_r}
        : hit_ctrl ? {29'h0, ctrl_r}
        : hit_dly ? {13'h0, dly_r}
        : hit_stat ? stat_w
        : hit_rem ? {{11{remain[CNT_W]}}, remain}
        : pf_or;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vld_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            vld_r <= psel & ~apb_done;
            if (psel & ~vld_r) begin
                prdata_r <= rd_val;
                pslverr_r <= ~known;
            end
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign outs = outs_r;
    assign evt_valid = evt_valid_r;
    assign evt = evt_r;
endmodule

// >>> verif/vts_assertions.sv
// Port-level checks of the supervision block: register bus answers and output events.
// Assumes clk_en stays high around the updates that the bench checks.
module vts_assertions
    import vts_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic meas_valid,
    input wire vts_meas_s meas,
    input wire logic block_in,
    input wire logic bus_breaker_trip_input,
    input wire logic line_breaker_trip_input,
    input wire logic stage_forcing_en,
    input wire vts_out_s outs,
    input wire logic evt_valid,
    input wire vts_evt_s evt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic upd = meas_valid && clk_en;
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_access;
        psel && penable && clk_en;
    endsequence
    a_apb_no_wait: assert property (s_setup ##1 s_access |-> pready)
        else $error("access cycle without ready");
    a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h2C))
        else $error("error response does not match the address map");
    a_err_read_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_outs_hold: assert property (!upd |=> $stable(outs))
        else $error("outputs moved between updates");
    a_evt_on_change: assert property ($changed(outs) |-> evt_valid)
        else $error("output edge without event");
    a_evt_edges: assert property (evt_valid |-> evt.rise == (4'(outs) & ~4'($past(outs)))
        && evt.fall == (4'($past(outs)) & ~4'(outs)))
        else $error("event edge bits wrong");
    a_evt_quiet: assert property (!upd && clk_en |=> !evt_valid && $stable(evt))
        else $error("event outside an update");
    a_block_no_start: assert property (upd && block_in && !stage_forcing_en |=> !outs.start)
        else $error("start raised while blocked");
endmodule

bind vts_supervision vts_assertions chk_u (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas, .block_in,
    .bus_breaker_trip_input, .line_breaker_trip_input, .stage_forcing_en, .outs, .evt_valid,
    .evt);

// >>> verif/vts_meas_model.sv
// Behavioural measurement front end: one value set per update strobe, angles rotating.
// Assumes the bench sets magnitudes and base angles; values are scrambled between strobes.
module vts_meas_model
    import vts_pkg::*;
#(
    parameter int UPD_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire vts_meas_s meas_set,
    input wire logic [ANG_W-1:0] ang_step,
    output logic meas_valid,
    output vts_meas_s meas
);
    int cnt;
    logic [ANG_W-1:0] rot;
    function automatic logic [ANG_W-1:0] wrap(input logic [ANG_W:0] a);
        return (a >= {1'b0, ANG_FULL}) ? ANG_W'(a - {1'b0, ANG_FULL}) : ANG_W'(a);
    endfunction
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            meas_valid <= 1'b0;
            rot <= '0;
            meas <= '0;
        end else begin
            cnt <= (cnt == UPD_CYC - 1) ? 0 : cnt + 1;
            meas_valid <= (cnt == UPD_CYC - 1);
            meas <= ~meas;
            if (cnt == UPD_CYC - 1) begin
                rot <= wrap({1'b0, rot} + {1'b0, ang_step});
                meas <= meas_set;
                for (int c = 0; c < NCH; c++) begin
                    meas.line_ang[c] <= wrap({1'b0, meas_set.line_ang[c]} + {1'b0, rot});
                    meas.phase_ang[c] <= wrap({1'b0, meas_set.phase_ang[c]} + {1'b0, rot});
                end
            end
        end
    end
endmodule

// >>> verif/tb.sv
// Self-checking bench of the supervision block with an APB master and a measurement model.
// Assumes updates every 20 cycles, so a delay setting counts updates, not real time.
module tb
    import vts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic block_in = 0, stage_forcing_en = 0;
    logic bus_breaker_trip_input = 0, line_breaker_trip_input = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, meas_valid, evt_valid, e;
    logic [ANG_W-1:0] ang_step = 12'h0C8;
    vts_meas_s meas, meas_set;
    vts_out_s outs;
    vts_evt_s evt;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    logic [27:0] rst_tbl [8] = '{28'h00_00001, 28'h04_00000, 28'h08_00005, 28'h0C_00050,
        28'h10_00032, 28'h14_00003, 28'h18_000C8, 28'h20_00000};
    logic [47:0] wr_tbl [19] = '{48'h00_00006_00001, 48'h00_00005_00005, 48'h00_00001_00001,
        48'h04_00005_00000, 48'h04_00004_00004, 48'h04_00000_00000, 48'h08_00004_00005,
        48'h08_00033_00005, 48'h08_00032_00032, 48'h08_00005_00005, 48'h0C_00000_00050,
        48'h0C_0006F_00050, 48'h0C_0006E_0006E, 48'h0C_00050_00050, 48'h10_00013_00032,
        48'h10_00385_00032, 48'h10_00032_00032, 48'h18_57E41_000C8, 48'h18_00002_00002};

    vts_meas_model #(.UPD_CYC(20)) model_u (.clk_sys, .rst_n, .meas_set, .ang_step,
        .meas_valid, .meas);
    vts_supervision #(.STAMP_CYCLES(10)) dut_u (.clk_sys, .rst_n, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas, .block_in,
        .bus_breaker_trip_input, .line_breaker_trip_input, .stage_forcing_en, .outs,
        .evt_valid, .evt);

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The request is held until pready is seen high; the bench timeout ends any hang.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk(32'(e), 32'(ee));
    endtask
    task automatic st(input logic [3:0] o, input logic [2:0] c, input logic [2:0] b);
        apb(1'b0, OFS_STAT, 32'h0);
        chk(32'(q[3:0]), 32'(o));
        chk(32'(q[10:8]), 32'(c));
        chk(32'(q[14:12]), 32'(b));
        chk(32'(q[16]), 32'(b == 3'h4));
    endtask
    task automatic upd(input int n);
        repeat (n) do @(posedge clk_sys); while (meas_valid !== 1'b1);
        @(posedge clk_sys);
    endtask
    task automatic norm();
        for (int c = 0; c < NCH; c++) begin
            meas_set.line_mag[c] <= 12'h03C;
            meas_set.phase_mag[c] <= 12'h03C;
            meas_set.line_ang[c] <= 12'(c * 1200);
            meas_set.phase_ang[c] <= 12'(c * 1200);
        end
        meas_set.positive_seq_voltage <= 12'h03C;
        meas_set.negative_seq_voltage <= 12'h000;
        meas_set.zero_seq_voltage <= 12'h000;
    endtask

    task automatic t_regs();
        foreach (rst_tbl[i]) rdc(rst_tbl[i][27:20], 32'(rst_tbl[i][19:0]), 1'b0);
        foreach (wr_tbl[i]) begin
            apb(1'b1, wr_tbl[i][47:40], 32'(wr_tbl[i][39:20]));
            rdc(wr_tbl[i][47:40], 32'(wr_tbl[i][19:0]), 1'b0);
        end
        apb(1'b1, 8'h40, 32'h1);
        chk(32'(e), 32'h1);
        rdc(8'h40, 32'h0, 1'b1);
        for (int m = 1; m <= 5; m++) begin
            apb(1'b1, OFS_MODE, 32'(m));
            apb(1'b0, OFS_STAT, 32'h0);
            chk(32'(q[6:4]), 32'(m));
        end
        apb(1'b1, OFS_MODE, 32'h1);
    endtask
    task automatic t_volt();
        upd(9);
        st(4'h0, 3'h0, 3'h1);
        meas_set.line_mag[0] <= 12'h002;
        upd(1);
        st(4'h1, 3'h1, 3'h4);
        rdc(OFS_PF0, 32'h3C, 1'b0);
        rdc(OFS_REMAIN, 32'h2, 1'b0);
        upd(2);
        st(4'h3, 3'h3, 3'h4);
        norm();
        upd(1);
        chk(32'(outs), 32'h0);
        meas_set.line_mag[0] <= 12'h002;
        upd(1);
        norm();
        upd(2);
        chk(32'(outs), 32'h0);
        meas_set.line_mag[1] <= 12'h05A;
        meas_set.line_mag[2] <= 12'h05A;
        upd(1);
        chk(32'(outs), 32'h1);
        norm();
        block_in <= 1'b1;
        meas_set.line_mag[0] <= 12'h002;
        upd(1);
        chk(32'(outs), 32'h8);
        block_in <= 1'b0;
        norm();
        ang_step <= 12'h000;
        upd(9);
        meas_set.line_mag[0] <= 12'h002;
        upd(1);
        chk(32'(outs), 32'h0);
        norm();
        ang_step <= 12'h0C8;
        apb(1'b1, OFS_CTRL, 32'h7);
        meas_set.line_mag[0] <= 12'h002;
        upd(9);
        chk(32'(outs), 32'h0);
        norm();
        apb(1'b1, OFS_CTRL, 32'h3);
        upd(2);
    endtask
    task automatic t_fuse();
        line_breaker_trip_input <= 1'b1;
        upd(1);
        chk(32'(outs[0]), 32'h1);
        upd(2);
        chk(32'(outs), 32'h5);
        apb(1'b1, OFS_CTRL, 32'h1);
        upd(1);
        chk(32'(outs), 32'h0);
        line_breaker_trip_input <= 1'b0;
        bus_breaker_trip_input <= 1'b1;
        upd(1);
        chk(32'(outs), 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        upd(1);
        chk(32'(outs), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h3);
        bus_breaker_trip_input <= 1'b0;
        upd(1);
    endtask
    task automatic t_mode();
        apb(1'b1, OFS_MODE, 32'h5);
        meas_set.line_mag[0] <= 12'h002;
        upd(2);
        st(4'h0, 3'h0, 3'h0);
        apb(1'b1, OFS_MODE, 32'h1);
        norm();
        stage_forcing_en <= 1'b1;
        for (int f = 0; f <= 4; f++) begin
            apb(1'b1, OFS_FORCE, 32'(f));
            upd(1);
            apb(1'b0, OFS_STAT, 32'h0);
            chk(32'(q[10:8]), 32'(f));
        end
        stage_forcing_en <= 1'b0;
        upd(1);
        st(4'h0, 3'h0, 3'h1);
        // Updates offered while the enable is low must be ignored.
        meas_set.line_mag[0] <= 12'h002;
        clk_en <= 1'b0;
        repeat (45) @(posedge clk_sys);
        chk(32'(outs), 32'h0);
        clk_en <= 1'b1;
        norm();
        upd(1);
    endtask

    initial begin
        norm();
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_volt();
        t_fuse();
        t_mode();
        end_sim();
    end
endmodule
